/* File: rtl/tcn_pkg.sv */
// Purpose: Shared constants and types of the dual timer/counter block
// Assumes: 32-bit classic Wishbone register bus, byte addresses, one clock
// Notes:   All registers sit in byte lane 0, at most 8 bits wide; upper bits read as zero
`default_nettype none
package tcn_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] TCN_OFF_MODE  = 8'h00;
  localparam logic [7:0] TCN_OFF_CTRL  = 8'h04;
  localparam logic [7:0] TCN_OFF_LO0   = 8'h08;
  localparam logic [7:0] TCN_OFF_HI0   = 8'h0C;
  localparam logic [7:0] TCN_OFF_LO1   = 8'h10;
  localparam logic [7:0] TCN_OFF_HI1   = 8'h14;
  localparam logic [7:0] TCN_OFF_CLK   = 8'h18;
  localparam logic [7:0] TCN_OFF_STAT  = 8'h1C;
  localparam logic [7:0] TCN_OFF_MASK  = 8'h20;

  // ==========================================================================
  // Field positions
  localparam int TCN_MODE_TMR0_LSB = 0;
  localparam int TCN_MODE_TMR0_SEL = 2;
  localparam int TCN_MODE_TMR0_GATE = 3;
  localparam int TCN_MODE_T1_LSB   = 4;
  localparam int TCN_MODE_T1_SEL   = 6;
  localparam int TCN_MODE_T1_GATE  = 7;
  localparam int TCN_CTRL_RUN0     = 4;
  localparam int TCN_CTRL_FLAG0    = 5;
  localparam int TCN_CTRL_RUN1     = 6;
  localparam int TCN_CTRL_FLAG1    = 7;
  localparam int TCN_CLK_SW_DBL    = 0;
  localparam int TCN_CLK_EFFECTIVE = 1;

  // ==========================================================================
  // Mode encodings
  localparam logic [1:0] TCN_MODE_13BIT  = 2'h0;
  localparam logic [1:0] TCN_MODE_16BIT  = 2'h1;
  localparam logic [1:0] TCN_MODE_RELOAD = 2'h2;
  localparam logic [1:0] TCN_MODE_SPLIT  = 2'h3;

  // ==========================================================================
  // Machine cycle length in oscillator periods
  localparam logic [3:0] TCN_MC_12CLK = 4'hC;
  localparam logic [3:0] TCN_MC_6CLK  = 4'h6;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic       ovf;
  } tcn_cnt_type;

  typedef struct packed {
    logic [2:0]  cnt0_sync;
    logic [2:0]  cnt1_sync;
    logic [1:0]  int0_sync;
    logic [1:0]  int1_sync;
    logic [1:0]  nv_sync;
    logic [3:0]  div;
    logic [7:0]  mode;
    logic        run0;
    logic        run1;
    logic [1:0]  flags;
    logic [1:0]  mask;
    logic        sw_dbl;
    logic [7:0]  lo0;
    logic [7:0]  hi0;
    logic [7:0]  lo1;
    logic [7:0]  hi1;
    logic        ack;
    logic [31:0] rdata;
    logic        irq;
  } tcn_state_type;

  localparam tcn_state_type TCN_STATE_RESET = '0;

endpackage : tcn_pkg

`default_nettype wire

/* File: rtl/tcn_timer.sv */
// Purpose: Two 8/13/16-bit timer/counters with machine cycle divider
// Assumes: mclk is the oscillator; pins are asynchronous to it
// Notes:   Registers reached over classic Wishbone, one ack per access
//
// Contract
// R1 - Select bit picks machine cycles or pin
// R2 - Two-bit field picks four modes per timer
// R3 - Mode 0 is a 13-bit counter
// R4 - Mode 0 uses high byte plus low five
// R5 - Wrap to zero sets overflow flag
// R6 - Count needs run and gate-or-pin high
// R7 - Starting run keeps the current count
// R8 - Gate bits at mode bits 7, 3
// R9 - Mode 1 counts all 16 bits
// R10 - Mode 2 reloads low from high byte
// R11 - Timer 1 mode 3 holds its count
// R12 - Timer 0 mode 3 low byte separate
// R13 - Timer 0 high byte uses timer 1 controls
// R14 - Software bit selects 12 or 6 clocks
// R15 - Nonvolatile bit forces 6-clock operation
// R16 - Machine cycle is 12 or 6 periods
// R17 - Partner drives count pins with events
// R18 - Pin counts on synchronised falling edges
// R19 - Flag sticks until cleared, requests interrupt
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module tcn_timer (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // External pins
  input  wire logic        timer0_count_input,
  input  wire logic        timer1_count_input,
  input  wire logic        external_interrupt_pin0_n,
  input  wire logic        external_interrupt_pin1_n,
  input  wire logic        nonvolatile_double_speed_bit,
  // Interrupt
  input  wire logic        timer0_int_ack,
  input  wire logic        timer1_int_ack,
  output logic             irq_o
);
  import tcn_pkg::*;

  // ==========================================================================
  // Counting step shared by both timers
  function automatic tcn_cnt_type tcn_step(input logic [1:0] mode,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
    tcn_cnt_type r;
    r.lo  = lo;
    r.hi  = hi;
    r.ovf = 1'b0;
    unique case (mode)
      // R3 13-bit count
      TCN_MODE_13BIT: begin
        // R4 upper low bits untouched
        r.ovf = (hi == 8'hFF) && (lo[4:0] == 5'h1F);
        {r.hi, r.lo[4:0]} = {hi, lo[4:0]} + 13'h0001;
      end
      // R9 full 16 bits
      TCN_MODE_16BIT: begin
        r.ovf = (hi == 8'hFF) && (lo == 8'hFF);
        {r.hi, r.lo} = {hi, lo} + 16'h0001;
      end
      // R10 reload low from high
      TCN_MODE_RELOAD: begin
        r.ovf = (lo == 8'hFF);
        r.lo  = r.ovf ? hi : lo + 8'h01;
      end
      // R12 low byte alone
      TCN_MODE_SPLIT: begin
        r.ovf = (lo == 8'hFF);
        r.lo  = lo + 8'h01;
      end
    endcase
    return r;
  endfunction

  // ==========================================================================
  // State
  tcn_state_type state_reg;
  tcn_state_type state_next;

  logic        double_speed;
  logic [3:0]  mc_period;
  logic        mc_tick;
  logic        edge0;
  logic        edge1;
  logic [1:0]  mode0;
  logic [1:0]  mode1;
  logic        split;
  logic        gate_ok0;
  logic        gate_ok1;
  logic        en0;
  logic        en1;
  logic        en0_high;
  logic [1:0]  flag_set;
  logic [1:0]  flag_clr;
  logic        wr;
  logic        rd;
  logic [7:0]  rbyte;
  logic [7:0]  wbyte;
  tcn_cnt_type step0;
  tcn_cnt_type step1;

  always_comb begin
    state_next = state_reg;

    // ========================================================================
    // Pin synchronisers; bit 0 feeds only bit 1, bit 2 is the edge history
    state_next.cnt0_sync = {state_reg.cnt0_sync[1:0], timer0_count_input};
    state_next.cnt1_sync = {state_reg.cnt1_sync[1:0], timer1_count_input};
    state_next.int0_sync = {state_reg.int0_sync[0], external_interrupt_pin0_n};
    state_next.int1_sync = {state_reg.int1_sync[0], external_interrupt_pin1_n};
    state_next.nv_sync   = {state_reg.nv_sync[0], nonvolatile_double_speed_bit};

    // ========================================================================
    // Machine cycle divider
    // R15 nonvolatile bit overrides
    double_speed = state_reg.nv_sync[1] | state_reg.sw_dbl;
    // R14 select cycle length
    mc_period = double_speed ? TCN_MC_6CLK : TCN_MC_12CLK;
    // R16 one tick per cycle; >= keeps a switch to 6 clocks from overrunning
    mc_tick = (state_reg.div >= mc_period - 4'h1);
    state_next.div = mc_tick ? 4'h0 : state_reg.div + 4'h1;

    // ========================================================================
    // Count enables
    // R18 falling edge after sync
    edge0 = state_reg.cnt0_sync[2] & ~state_reg.cnt0_sync[1];
    edge1 = state_reg.cnt1_sync[2] & ~state_reg.cnt1_sync[1];
    // R2 per-timer mode field
    mode0 = state_reg.mode[TCN_MODE_TMR0_LSB +: 2];
    mode1 = state_reg.mode[TCN_MODE_T1_LSB +: 2];
    split = (mode0 == TCN_MODE_SPLIT);
    // R8 gate bit positions
    // R6 gate passes when pin high
    gate_ok0 = ~state_reg.mode[TCN_MODE_TMR0_GATE] | state_reg.int0_sync[1];
    gate_ok1 = ~state_reg.mode[TCN_MODE_T1_GATE] | state_reg.int1_sync[1];
    // R1 timer or counter
    en0 = state_reg.run0 & gate_ok0 & (state_reg.mode[TCN_MODE_TMR0_SEL] ? edge0 : mc_tick);
    // R11 mode 3 holds timer 1
    // Timer 1 run bit is lent to the split high byte, so it free-runs then
    en1 = (split | state_reg.run1) & gate_ok1 & (mode1 != TCN_MODE_SPLIT)
          & (state_reg.mode[TCN_MODE_T1_SEL] ? edge1 : mc_tick);
    // R13 high byte on timer 1 run
    en0_high = split & state_reg.run1 & mc_tick;

    // ========================================================================
    // Counters
    flag_set = 2'b00;
    step0 = tcn_step(mode0, state_reg.lo0, state_reg.hi0);
    step1 = tcn_step(mode1, state_reg.lo1, state_reg.hi1);
    if (en0) begin
      state_next.lo0 = step0.lo;
      state_next.hi0 = step0.hi;
      // R5 wrap sets flag
      flag_set[0] = step0.ovf;
    end
    if (en0_high) begin
      state_next.hi0 = state_reg.hi0 + 8'h01;
      // R13 sets timer 1 flag
      flag_set[1] = (state_reg.hi0 == 8'hFF);
    end
    if (en1) begin
      state_next.lo1 = step1.lo;
      state_next.hi1 = step1.hi;
      // Timer 1 flag belongs to the high byte of timer 0 while split
      flag_set[1] = flag_set[1] | (step1.ovf & ~split);
    end

    // ========================================================================
    // Wishbone: data and ack one edge after the request, write at the ack edge
    rd = wb_cyc_i & wb_stb_i & ~state_reg.ack;
    wr = wb_cyc_i & wb_stb_i & wb_we_i & state_reg.ack & wb_sel_i[0];
    wbyte = wb_dat_i[7:0];
    state_next.ack = rd;
    unique case (wb_adr_i)
      TCN_OFF_MODE: rbyte = state_reg.mode;
      TCN_OFF_CTRL: rbyte = {state_reg.flags[1], state_reg.run1, state_reg.flags[0], state_reg.run0, 4'h0};
      TCN_OFF_LO0:  rbyte = state_reg.lo0;
      TCN_OFF_HI0:  rbyte = state_reg.hi0;
      TCN_OFF_LO1:  rbyte = state_reg.lo1;
      TCN_OFF_HI1:  rbyte = state_reg.hi1;
      TCN_OFF_CLK:  rbyte = {6'h00, double_speed, state_reg.sw_dbl};
      TCN_OFF_STAT: rbyte = {6'h00, state_reg.flags};
      TCN_OFF_MASK: rbyte = {6'h00, state_reg.mask};
      default:      rbyte = 8'h00;
    endcase
    if (rd) begin
      state_next.rdata = {24'h000000, rbyte};
    end

    flag_clr = {timer1_int_ack, timer0_int_ack};
    if (wr) begin
      unique case (wb_adr_i)
        TCN_OFF_MODE: state_next.mode = wbyte;
        TCN_OFF_CTRL: begin
          // R7 run bit leaves count alone
          state_next.run0 = wbyte[TCN_CTRL_RUN0];
          state_next.run1 = wbyte[TCN_CTRL_RUN1];
        end
        // Software load beats a count in the same cycle
        TCN_OFF_LO0:  state_next.lo0 = wbyte;
        TCN_OFF_HI0:  state_next.hi0 = wbyte;
        TCN_OFF_LO1:  state_next.lo1 = wbyte;
        TCN_OFF_HI1:  state_next.hi1 = wbyte;
        // R14 writable any time
        TCN_OFF_CLK:  state_next.sw_dbl = wbyte[TCN_CLK_SW_DBL];
        TCN_OFF_STAT: flag_clr = flag_clr | wbyte[1:0];
        TCN_OFF_MASK: state_next.mask = wbyte[1:0];
        default: ;
      endcase
    end

    // ========================================================================
    // R19 sticky flags, set beats clear
    state_next.flags = (state_reg.flags & ~flag_clr) | flag_set;
    state_next.irq   = |(state_next.flags & state_next.mask);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= TCN_STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_dat_o = state_reg.rdata;
  assign wb_ack_o = state_reg.ack;
  assign irq_o    = state_reg.irq;

endmodule : tcn_timer

`default_nettype wire

/* File: sim/tcn_timer_checker.sv */
// Purpose: Port assertions for the dual timer/counter
// Assumes: Master releases the bus at the ack edge
// Notes:   Shadows follow mode and mask writes
`timescale 1ns/10ps
`default_nettype none
module tcn_timer_checker (
  // Clock and bus
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Pins
  input wire logic        nonvolatile_double_speed_bit,
  input wire logic        irq_o
);
  import tcn_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Shadows; mask lags one cycle since irq may use either copy
  logic [7:0] mode_reg;
  logic [1:0] mask_reg;
  logic [1:0] mask_old_reg;
  wire logic  wr_hit = wb_ack_o & wb_we_i & wb_sel_i[0];
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode_reg     <= 8'h00;
      mask_reg     <= 2'h0;
      mask_old_reg <= 2'h0;
    end else begin
      mask_old_reg <= mask_reg;
      if (wr_hit && wb_adr_i == TCN_OFF_MODE) mode_reg <= wb_dat_i[7:0];
      if (wr_hit && wb_adr_i == TCN_OFF_MASK) mask_reg <= wb_dat_i[1:0];
    end
  end
  // ==========================================================
  // Assertions
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd(logic [7:0] a);
    wb_ack_o && !wb_we_i && wb_adr_i == a;
  endsequence
  a_ack_prompt:
    assert property (s_req |=> wb_ack_o) else $error("ack late");
  a_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_caused:
    assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i)) else $error("ack unasked");
  a_upper_zero:
    assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
  a_unmapped_zero:
    assert property (s_rd(8'h24) |-> wb_dat_o == 32'h0) else $error("unmapped not zero");
  a_mode_readback:
    assert property (s_rd(TCN_OFF_MODE) |-> wb_dat_o[7:0] == mode_reg) else $error("mode readback");
  a_clk_forced:
    assert property (nonvolatile_double_speed_bit [*6] ##0 s_rd(TCN_OFF_CLK) |-> wb_dat_o[1])
      else $error("six clock not forced");
  a_irq_masked:
    assert property (irq_o |-> (mask_reg != 2'h0 || mask_old_reg != 2'h0)) else $error("irq unmasked");
endmodule // tcn_timer_checker
bind tcn_timer tcn_timer_checker u_chk (
  .mclk(mclk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .nonvolatile_double_speed_bit(nonvolatile_double_speed_bit), .irq_o(irq_o));
`default_nettype wire

/* File: sim/tcn_pin_model.sv */
// Purpose: Count and gate pins driven from outside
// Assumes: Pins have pull-ups, idle high
// Notes:   Tasks are called by the bench
`timescale 1ns/10ps
`default_nettype none
module tcn_pin_model (
  // Pins
  input  wire logic mclk,
  output logic      cnt0,
  output logic      cnt1,
  output logic      gate0,
  output logic      gate1
);
  initial {cnt0, cnt1, gate0, gate1} = 4'hF;
  task automatic pulses(input logic w, input int n);
    repeat (n) begin
      repeat (4) @(posedge mclk);
      if (w) cnt1 <= 1'b0; else cnt0 <= 1'b0;
      repeat (4) @(posedge mclk);
      {cnt0, cnt1} <= 2'h3;
    end
  endtask
  task automatic gate(input logic w, input logic v);
    @(posedge mclk);
    if (w) gate1 <= v; else gate0 <= v;
  endtask
endmodule // tcn_pin_model
`default_nettype wire

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench for the dual timer/counter
// Assumes: 250 MHz mclk, ack one cycle after request
// Notes:   Pin model supplies count and gate pins
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import tcn_pkg::*;
  // ==========================================================
  // Signals
  logic mclk, rstn, cyc, stb, we, nv, ack0, ack1, irq, ack, c0, c1, g0, g1;
  logic [7:0] adr;
  logic [31:0] wdat, rdat;
  int fails, check_count, c;
  tcn_timer dut (.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .timer0_count_input(c0), .timer1_count_input(c1), .external_interrupt_pin0_n(g0),
    .external_interrupt_pin1_n(g1), .nonvolatile_double_speed_bit(nv),
    .timer0_int_ack(ack0), .timer1_int_ack(ack1), .irq_o(irq));
  tcn_pin_model pm (.mclk(mclk), .cnt0(c0), .cnt1(c1), .gate0(g0), .gate1(g1));
  // ==========================================================
  // Bus and compare tasks
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    {cyc, stb, we, adr, wdat} <= {3'h7, a, 24'h0, d};
    do @(posedge mclk); while (ack !== 1'b1);
    {cyc, stb, we} <= 3'h0;
  endtask
  task automatic rdc(input string s, input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    {cyc, stb, we, adr} <= {3'h6, a};
    do @(posedge mclk); while (ack !== 1'b1);
    chk(s, e, rdat[7:0]);
    {cyc, stb} <= 2'h0;
  endtask
  task automatic wirq(input int n);
    c = 0;
    while (irq !== 1'b1 && c < n) begin
      @(posedge mclk);
      c++;
    end
  endtask
  task automatic pk(input logic w);
    @(posedge mclk);
    if (w) ack1 <= 1'b1; else ack0 <= 1'b1;
    @(posedge mclk);
    {ack0, ack1} <= 2'h0;
  endtask
  // ==========================================================
  // Tests
  task automatic t_regs;
    rdc("mode_rst", TCN_OFF_MODE, 8'h00);
    wr(TCN_OFF_MODE, 8'hA5);
    rdc("mode_rw", TCN_OFF_MODE, 8'hA5);
    rdc("unmapped", 8'h24, 8'h00);
    wr(TCN_OFF_CLK, 8'h01);
    rdc("clk_sw", TCN_OFF_CLK, 8'h03);
    wr(TCN_OFF_CLK, 8'h00);
    nv <= 1'b1;
    repeat (4) @(posedge mclk);
    rdc("clk_nv", TCN_OFF_CLK, 8'h02);
    nv <= 1'b0;
    $display("regs done");
  endtask
  task automatic t_wrap;
    // Mode, low address, low, high, run, low after, high after
    logic [7:0] k [6][7] = '{'{8'h00, TCN_OFF_LO0, 8'hFF, 8'hFF, 8'h10, 8'hE0, 8'h00},
      '{8'h01, TCN_OFF_LO0, 8'hFF, 8'hFF, 8'h10, 8'h00, 8'h00},
      '{8'h02, TCN_OFF_LO0, 8'hFF, 8'h7A, 8'h10, 8'h7A, 8'h7A},
      '{8'h00, TCN_OFF_LO1, 8'hFF, 8'hFF, 8'h40, 8'hE0, 8'h00},
      '{8'h20, TCN_OFF_LO1, 8'hFF, 8'hF0, 8'h40, 8'hF0, 8'hF0},
      '{8'h33, TCN_OFF_LO0, 8'h00, 8'hFF, 8'h40, 8'h00, 8'h00}};
    for (int i = 0; i < 6; i++) begin
      wr(k[i][1], k[i][2]);
      wr(k[i][1] + 8'h04, k[i][3]);
      wr(TCN_OFF_MODE, k[i][0]);
      wr(TCN_OFF_MASK, {6'h0, k[i][4][6], k[i][4][4]});
      wr(TCN_OFF_CTRL, k[i][4]);
      wirq(30);
      chk("irq_set", 8'h01, {7'h0, irq});
      wr(TCN_OFF_CTRL, 8'h00);
      repeat (20) @(posedge mclk);
      chk("irq_held", 8'h01, {7'h0, irq});
      rdc("lo", k[i][1], k[i][5]);
      rdc("hi", k[i][1] + 8'h04, k[i][6]);
      pk(k[i][4][6]);
      rdc("stat_clr", TCN_OFF_STAT, 8'h00);
    end
    rdc("t1_hold", TCN_OFF_LO1, 8'hF0);
    $display("wrap done");
  endtask
  task automatic t_count;
    // Both timers as gated pin counters; timer 1 also exercises gate bit 7
    for (int w = 0; w < 2; w++) begin
      wr(w ? TCN_OFF_LO1 : TCN_OFF_LO0, 8'h00);
      wr(TCN_OFF_MODE, w ? 8'hD0 : 8'h0D);
      wr(TCN_OFF_CTRL, w ? 8'h40 : 8'h10);
      pm.gate(w[0], 1'b0);
      pm.pulses(w[0], 3);
      rdc("gated", w ? TCN_OFF_LO1 : TCN_OFF_LO0, 8'h00);
      pm.gate(w[0], 1'b1);
      pm.pulses(w[0], 3);
      repeat (4) @(posedge mclk);
      rdc("counted", w ? TCN_OFF_LO1 : TCN_OFF_LO0, 8'h03);
      wr(TCN_OFF_CTRL, 8'h00);
    end
    $display("count done");
  endtask
  task automatic t_speed;
    for (int x = 0; x < 2; x++) begin
      wr(TCN_OFF_CLK, x[7:0]);
      wr(TCN_OFF_LO0, 8'hFC);
      wr(TCN_OFF_HI0, 8'hFF);
      wr(TCN_OFF_MODE, 8'h01);
      wr(TCN_OFF_MASK, 8'h01);
      wr(TCN_OFF_CTRL, 8'h10);
      wirq(100);
      chk("period", 8'h01, {7'h0, c >= 36 / (x + 1) && c <= (x ? 28 : 52)});
      wr(TCN_OFF_CTRL, 8'h00);
      wr(TCN_OFF_MASK, 8'h00);
      repeat (2) @(posedge mclk);
      chk("masked", 8'h00, {7'h0, irq});
      rdc("sticky", TCN_OFF_STAT, 8'h01);
      wr(TCN_OFF_STAT, 8'h01);
      rdc("w1c", TCN_OFF_STAT, 8'h00);
    end
    $display("speed done");
  endtask
  task automatic t_reset;
    // Reset in mid-run with a pending interrupt and 6-clock mode selected
    wr(TCN_OFF_LO0, 8'hFF);
    wr(TCN_OFF_HI0, 8'hFF);
    wr(TCN_OFF_MASK, 8'h01);
    wr(TCN_OFF_CTRL, 8'h10);
    wirq(30);
    chk("irq_pre", 8'h01, {7'h0, irq});
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    chk("irq_rst", 8'h00, {7'h0, irq});
    rdc("ctrl_rst", TCN_OFF_CTRL, 8'h00);
    rdc("clk_rst", TCN_OFF_CLK, 8'h00);
    $display("reset done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================
  // Clock, sequence, watchdog
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    {rstn, cyc, stb, we, nv, ack0, ack1, adr, wdat} = '0;
    fails = 0;
    check_count = 0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    t_regs();
    t_wrap();
    t_count();
    t_speed();
    t_reset();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    conclude();
  end
endmodule // tb_top
`default_nettype wire
